// ===== common/flash_lock_regs.svh
// flash_lock_regs.svh: opcodes, field positions, timing figures and the
// host register map; assumes a 10 MHz core clock on both ends.
// How it works
// - lock bits protect only when per-unit select set
// - otherwise range bits decide, lock bits ignored
// - all lock bits are 1 after any reset
// - 36h with address sets one lock bit
// - 39h with address clears one lock bit
// - lock instructions ignored without write enable latch
// - 3Dh with address returns lock byte MSB first
// - returned LSB 1 locked, 0 unlocked
// - 7Eh alone sets every lock bit
// - 98h alone clears every lock bit
// - software reset restores all volatile power-on defaults
// - only 66h directly followed by 99h resets
// - any other instruction after 66h disarms reset
// - no instruction accepted for 30us after reset
// - host checks busy and paused before resetting
// - host waits 5 ms after power-up
// - busy reads 1 while self-timed erase/program runs, 0 while it is suspended
`ifndef FLASH_LOCK_REGS_SVH
`define FLASH_LOCK_REGS_SVH

// instruction codes
`define OP_WRITE_EN 8'h06
`define OP_WRITE_DIS 8'h04
`define OP_READ_SR1 8'h05
`define OP_READ_SR2 8'h35
`define OP_LOCK 8'h36
`define OP_UNLOCK 8'h39
`define OP_READ_LOCK 8'h3D
`define OP_GLOBAL_LOCK 8'h7E
`define OP_GLOBAL_UNLOCK 8'h98
`define OP_RESET_EN 8'h66
`define OP_RESET 8'h99
`define OP_ERASE 8'h20
`define OP_PROGRAM 8'h02
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_WRAP 8'h77

// frame lengths in link clocks
`define FRAME_OP_BITS 6'h08
`define FRAME_ADDR_BITS 6'h20
`define BIT_CNT_MAX 6'h3F

// status byte bit positions
`define SR1_BUSY 0
`define SR1_WEL 1
`define SR2_PAUSED 7

// protection map: 64 KB blocks, ends split into 4 KB sectors
`define LOCK_UNITS 94
`define BLK_TOP 6'h3F
`define SECT_TOP_BASE 7'h10
`define BLK_BASE 7'h1F
`define SECT_SPAN 23'h001000
`define BLOCK_SPAN 23'h010000
`define ARRAY_SPAN 23'h400000

// timing
`define CLK_NS 100
`define RESET_RECOVER_NS 30000
`define RESET_RECOVER_CYC ((`RESET_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`define HOST_RECOVER_CYC (`RESET_RECOVER_CYC + 4)
`define POWERUP_WRITE_MS 5
`define POWERUP_WRITE_CYC (`POWERUP_WRITE_MS * 1000000 / `CLK_NS)
`define DESELECT_NS 50
`define CS_GAP_CYC ((`DESELECT_NS + `CLK_NS - 1) / `CLK_NS + 2)
`define ARRAY_OP_CYC 400

// host register map
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_STAT 8'h08
`endif

// ===== common/flash_lock_pkg.sv
// flash_lock_pkg: state types of both ends.
// assumes flash_lock_regs.svh is on the include path.
`include "flash_lock_regs.svh"
package flash_lock_pkg;
    // link-side capture of the device
    typedef struct packed {
        logic [5:0] bitCnt;
        logic [31:0] shift;
        logic [7:0] opcode;
    } link_state_t;

    // device core-clock state
    typedef struct packed {
        logic csSeen;
        logic [`LOCK_UNITS-1:0] lockBits;
        logic write_enable_latch;
        logic paused;
        logic armed;
        logic [15:0] opCnt;
        logic [15:0] recov;
        logic arrayStart;
        logic arrayErase;
        logic [23:0] arrayAddr;
        logic [2:0] wrap;
    } dev_state_t;

    typedef enum logic [2:0] {H_POWER, H_IDLE, H_LOAD, H_SHIFT, H_GAP, H_RECOVER} host_phase_t;

    typedef struct packed {
        host_phase_t phase;
        logic [15:0] cnt;
        logic [3:0] div;
        logic [1:0] step;
        logic [7:0] reqOp;
        logic [23:0] addr;
        logic [31:0] txSr;
        logic [7:0] rxSr;
        logic [7:0] lastRx;
        logic [5:0] bitCnt;
        logic [5:0] txBits;
        logic [5:0] total;
        logic csN;
        logic sclk;
        logic refused;
        logic [31:0] rdata;
    } host_state_t;
endpackage

// ===== common/spi_link_if.sv
// spi_link_if: the serial link between host and flash device.
// assumes the host makes sclk; miso idles high through a pull-up.
`timescale 1ns/1ps
interface spi_link_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic miso;
    logic misoOe;
    logic misoLine;
    // resolved wire: pulled high while the device lets go
    assign misoLine = misoOe ? miso : 1'h1;
    modport host (output csN, output sclk, output mosi, input misoLine);
    modport dev (input csN, input sclk, input mosi, output miso, output misoOe);
endinterface

// ===== hdl/bit_sync.sv
// bit_sync: two-stage synchroniser for one level.
// assumes din is a level that holds for more than a destination cycle.
`timescale 1ns/1ps
module bit_sync #(
    parameter logic INIT = 1'h0 // value after reset
) (
    input wire logic clk, // destination clock
    input wire logic rst, // synchronous, active high
    input wire logic din, // asynchronous level
    output logic dout // synchronised level
);
    logic [1:0] stages;
    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
            stages <= {INIT, INIT};
        else
            stages <= {stages[0], din};
    end
    assign dout = stages[1];
endmodule

// ===== hdl/flash_lock_dev.sv
// flash_lock_dev: lock-bit and software-reset logic of the flash device.
// assumes the host stops sclk outside frames and keeps cs high for at
// least three core cycles between frames.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_lock_regs.svh"
module flash_lock_dev #(
    parameter int ARRAY_OP_CYC = `ARRAY_OP_CYC // self-timed op length
) (
    input wire logic core_clk, // device core clock
    input wire logic rst, // synchronous, active high
    spi_link_if.dev link, // serial link, device end
    input wire logic perUnitProtectSelect, // lock bits in force
    input wire logic complementProtect, // invert range
    input wire logic smallUnitSelect, // range in 4 KB units
    input wire logic topBottomSelect, // range from bottom
    input wire logic [2:0] protectRangeBits, // range size
    output logic busy, // self-timed op running
    output logic writeEnableLatch, // write enable latch
    output logic pausedOperationFlag, // op suspended
    output logic recovering, // reset recovery running
    output logic arrayOpStart, // pulse: op accepted
    output logic arrayOpErase, // accepted op is an erase
    output logic [23:0] arrayOpAddr, // accepted op address
    output logic [2:0] wrapSettingBits // wrap setting
);
    import flash_lock_pkg::*;

    link_state_t lnk;
    link_state_t next_lnk;
    dev_state_t st;
    dev_state_t next_st;
    logic newFrame;
    logic misoBit;
    logic misoDrive;
    logic [7:0] respByte;
    logic respRead;
    logic [5:0] respStart;
    logic [5:0] respIdx;
    logic csSync;
    logic frameEnd;
    logic [7:0] op;
    logic [23:0] fAddr;
    logic [6:0] unit;
    logic opOnly;
    logic addrExact;
    logic protect;

    // fixed protection map, one bit per unit
    function automatic logic [6:0] lock_unit(input logic [23:0] a);
        logic [5:0] blk;
        blk = a[21:16];
        if (blk == 6'h00)
            return {3'h0, a[15:12]};
        else if (blk == `BLK_TOP)
            return `SECT_TOP_BASE + {3'h0, a[15:12]};
        else
            return `BLK_BASE + {1'h0, blk};
    endfunction

    // range protection from the status fields
    function automatic logic range_protect(input logic [23:0] a);
        logic [22:0] span;
        logic [22:0] off;
        logic hit;
        span = smallUnitSelect ? `SECT_SPAN : `BLOCK_SPAN;
        span = span << (protectRangeBits - 3'h1);
        off = {1'h0, a[21:0]};
        hit = topBottomSelect ? (off < span) : (off >= `ARRAY_SPAN - span);
        return ((protectRangeBits != 3'h0) && hit) ^ complementProtect;
    endfunction

    // cs high arms a fresh frame; sclk may stand still after cs rises
    always_ff @(posedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
            newFrame <= 1'h1;
        else
            newFrame <= 1'h0;
    end

    // shift opcode and address in on rising sclk, msb first
    always_comb
    begin
        next_lnk = lnk;
        if (newFrame)
        begin
            next_lnk.bitCnt = 6'h01;
            next_lnk.shift = {31'h0, link.mosi};
        end
        else
        begin
            if (lnk.bitCnt != `BIT_CNT_MAX)
                next_lnk.bitCnt = lnk.bitCnt + 6'h01;
            // freeze after opcode and address so the core can read them
            if (lnk.bitCnt < `FRAME_ADDR_BITS)
                next_lnk.shift = {lnk.shift[30:0], link.mosi};
        end
        if (next_lnk.bitCnt == `FRAME_OP_BITS)
            next_lnk.opcode = next_lnk.shift[7:0];
    end

    // no reset: every frame restarts the capture itself
    always_ff @(posedge link.sclk)
    begin
        lnk <= next_lnk;
    end

    // answer byte; core flops are read quasi-static, they only move
    // between frames except the busy and write enable bits, which may flip mid-answer when an op ends
    always_comb
    begin
        respStart = (lnk.opcode == `OP_READ_LOCK) ? `FRAME_ADDR_BITS : `FRAME_OP_BITS;
        respIdx = lnk.bitCnt - respStart;
        respRead = 1'h1;
        respByte = 8'h00;
        case (lnk.opcode)
            `OP_READ_SR1:
            begin
                respByte[`SR1_BUSY] = busy;
                respByte[`SR1_WEL] = st.write_enable_latch;
            end
            `OP_READ_SR2:
                respByte[`SR2_PAUSED] = st.paused;
            `OP_READ_LOCK:
                respByte[0] = st.lockBits[lock_unit(lnk.shift[23:0])];
            default:
                respRead = 1'h0;
        endcase
    end

    // drive the answer on falling sclk; cs high releases the line at once
    always_ff @(negedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
        begin
            misoBit <= 1'h0;
            misoDrive <= 1'h0;
        end
        else if (respRead && lnk.bitCnt >= respStart)
        begin
            misoBit <= respByte[3'h7 - respIdx[2:0]];
            misoDrive <= 1'h1;
        end
    end
    assign link.miso = misoBit;
    assign link.misoOe = misoDrive;

    bit_sync #(
        .INIT(1'h1)
    ) u_cs_sync (
        .clk(core_clk),
        .rst(rst),
        .din(link.csN),
        .dout(csSync)
    );

    // frame decode; lnk is stable once cs is high because sclk stopped
    always_comb
    begin
        frameEnd = csSync & ~st.csSeen;
        op = lnk.opcode;
        fAddr = lnk.shift[23:0];
        unit = lock_unit(fAddr);
        opOnly = (lnk.bitCnt == `FRAME_OP_BITS);
        addrExact = (lnk.bitCnt == `FRAME_ADDR_BITS);
        protect = perUnitProtectSelect ? st.lockBits[unit] : range_protect(fAddr);
    end

    // instruction execution at the end of each frame
    always_comb
    begin
        next_st = st;
        next_st.csSeen = csSync;
        next_st.arrayStart = 1'h0;
        // self-timed op holds while suspended
        if (st.opCnt != 16'h0000 && !st.paused)
        begin
            next_st.opCnt = st.opCnt - 16'h0001;
            if (st.opCnt == 16'h0001)
                next_st.write_enable_latch = 1'h0;
        end
        if (st.recov != 16'h0000)
            next_st.recov = st.recov - 16'h0001;
        if (frameEnd && st.recov == 16'h0000)
        begin
            next_st.armed = opOnly && op == `OP_RESET_EN;
            if (opOnly && op == `OP_RESET && st.armed)
            begin
                next_st.lockBits = '1;
                next_st.write_enable_latch = 1'h0;
                next_st.paused = 1'h0;
                next_st.opCnt = 16'h0000;
                next_st.wrap = 3'h0;
                next_st.recov = 16'(`RESET_RECOVER_CYC);
            end
            else if (st.opCnt == 16'h0000)
            begin
                case (op)
                    `OP_WRITE_EN:
                        if (opOnly)
                            next_st.write_enable_latch = 1'h1;
                    `OP_WRITE_DIS:
                        if (opOnly)
                            next_st.write_enable_latch = 1'h0;
                    `OP_LOCK:
                        if (addrExact && st.write_enable_latch)
                            next_st.lockBits[unit] = 1'h1;
                    `OP_UNLOCK:
                        if (addrExact && st.write_enable_latch)
                            next_st.lockBits[unit] = 1'h0;
                    `OP_GLOBAL_LOCK:
                        if (opOnly && st.write_enable_latch)
                            next_st.lockBits = '1;
                    `OP_GLOBAL_UNLOCK:
                        if (opOnly && st.write_enable_latch)
                            next_st.lockBits = '0;
                    `OP_ERASE, `OP_PROGRAM:
                        // targets protected by the selected scheme (lock bit if perUnitProtectSelect, else range) are dropped
                        if (lnk.bitCnt >= `FRAME_ADDR_BITS && st.write_enable_latch && !protect)
                        begin
                            next_st.opCnt = 16'(ARRAY_OP_CYC);
                            next_st.arrayStart = 1'h1;
                            next_st.arrayErase = (op == `OP_ERASE);
                            next_st.arrayAddr = fAddr;
                        end
                    `OP_WRAP:
                        if (addrExact)
                            next_st.wrap = fAddr[6:4];
                    default:
                        next_st.wrap = st.wrap;
                endcase
            end
            else if (opOnly && op == `OP_SUSPEND)
                next_st.paused = 1'h1;
            else if (opOnly && op == `OP_RESUME)
                next_st.paused = 1'h0;
        end
    end

    // power-on defaults under rst
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.csSeen <= 1'h1;
            st.lockBits <= '1;
        end
        else
            st <= next_st;
    end

    // busy drops while suspended so status polling sees it free
    assign busy = (st.opCnt != 16'h0000) && !st.paused;
    assign writeEnableLatch = st.write_enable_latch;
    assign pausedOperationFlag = st.paused;
    assign recovering = (st.recov != 16'h0000);
    assign arrayOpStart = st.arrayStart;
    assign arrayOpErase = st.arrayErase;
    assign arrayOpAddr = st.arrayAddr;
    assign wrapSettingBits = st.wrap;
endmodule

// ===== hdl/flash_lock_host.sv
// flash_lock_host: host controller issuing lock and reset instructions.
// assumes software on the register port; device end on spi_link_if.
`timescale 1ns/1ps
`include "flash_lock_regs.svh"
module flash_lock_host #(
    parameter int POWERUP_CYC = `POWERUP_WRITE_CYC, // power-up wait
    parameter int SCLK_HALF = 4 // core cycles per sclk half, at least 3
) (
    input wire logic core_clk, // core clock
    input wire logic rst, // synchronous, active high
    spi_link_if.host link, // serial link, host end
    input wire logic [7:0] regAddr, // register byte address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    output logic [31:0] regRdata // read data, cycle after strobe
);
    import flash_lock_pkg::*;

    host_state_t h;
    host_state_t next_h;
    logic misoSync;
    logic [7:0] frameOp;
    logic withAddr;
    logic withRx;
    logic refuse;
    logic needWel;

    bit_sync #(
        .INIT(1'h1)
    ) u_miso_sync (
        .clk(core_clk),
        .rst(rst),
        .din(link.misoLine),
        .dout(misoSync)
    );

    // frame plan for the current step of the request
    always_comb
    begin
        needWel = h.reqOp inside {`OP_LOCK, `OP_UNLOCK, `OP_GLOBAL_LOCK,
                                  `OP_GLOBAL_UNLOCK, `OP_ERASE, `OP_PROGRAM};
        frameOp = h.reqOp;
        refuse = 1'h0;
        if (needWel && h.step == 2'h0)
            frameOp = `OP_WRITE_EN;
        else if (h.reqOp == `OP_RESET)
        begin
            // an erase running or suspended must not be cut short
            case (h.step)
                2'h0:
                    frameOp = `OP_READ_SR1;
                2'h1:
                begin
                    frameOp = `OP_READ_SR2;
                    refuse = h.lastRx[`SR1_BUSY];
                end
                2'h2:
                begin
                    frameOp = `OP_RESET_EN;
                    refuse = h.lastRx[`SR2_PAUSED];
                end
                default:
                    frameOp = `OP_RESET;
            endcase
        end
        withAddr = frameOp inside {`OP_LOCK, `OP_UNLOCK, `OP_READ_LOCK,
                                   `OP_ERASE, `OP_PROGRAM, `OP_WRAP};
        withRx = frameOp inside {`OP_READ_SR1, `OP_READ_SR2, `OP_READ_LOCK};
    end

    // register port and sequencer
    always_comb
    begin
        next_h = h;
        next_h.rdata = 32'h0000_0000;
        if (regRead && regAddr == `REG_ADDR)
            next_h.rdata = {8'h00, h.addr};
        else if (regRead && regAddr == `REG_STAT)
            next_h.rdata = {16'h0000, h.lastRx, 5'h00, h.phase != H_POWER,
                            h.refused, h.phase != H_IDLE};
        if (regWrite && regAddr == `REG_ADDR)
            next_h.addr = regWdata[23:0];
        if (regWrite && regAddr == `REG_CMD && h.phase != H_IDLE)
            next_h.refused = 1'h1;
        case (h.phase)
            H_POWER:
                if (h.cnt == 16'h0000)
                    next_h.phase = H_IDLE;
                else
                    next_h.cnt = h.cnt - 16'h0001;
            H_IDLE:
                if (regWrite && regAddr == `REG_CMD)
                begin
                    next_h.reqOp = regWdata[7:0];
                    next_h.step = 2'h0;
                    next_h.refused = 1'h0;
                    next_h.phase = H_LOAD;
                end
            H_LOAD:
                if (refuse)
                begin
                    next_h.refused = 1'h1;
                    next_h.phase = H_IDLE;
                end
                else
                begin
                    next_h.txSr = {frameOp, h.addr};
                    next_h.txBits = withAddr ? `FRAME_ADDR_BITS : `FRAME_OP_BITS;
                    next_h.total = next_h.txBits + (withRx ? `FRAME_OP_BITS : 6'h00);
                    next_h.bitCnt = 6'h00;
                    next_h.div = 4'(SCLK_HALF - 1);
                    next_h.csN = 1'h0;
                    next_h.phase = H_SHIFT;
                end
            H_SHIFT:
                if (h.div != 4'h0)
                    next_h.div = h.div - 4'h1;
                else
                begin
                    next_h.div = 4'(SCLK_HALF - 1);
                    next_h.sclk = ~h.sclk;
                    if (!h.sclk)
                    begin
                        // synced miso lags two cycles, still after the fall
                        next_h.bitCnt = h.bitCnt + 6'h01;
                        if (h.bitCnt >= h.txBits)
                            next_h.rxSr = {h.rxSr[6:0], misoSync};
                    end
                    else
                    begin
                        next_h.txSr = {h.txSr[30:0], 1'h0};
                        if (h.bitCnt == h.total)
                        begin
                            next_h.csN = 1'h1;
                            next_h.lastRx = h.rxSr;
                            next_h.cnt = 16'(`CS_GAP_CYC);
                            next_h.phase = H_GAP;
                        end
                    end
                end
            H_GAP:
                if (h.cnt != 16'h0000)
                    next_h.cnt = h.cnt - 16'h0001;
                else if ((needWel && h.step == 2'h0) ||
                         (h.reqOp == `OP_RESET && h.step != 2'h3))
                begin
                    next_h.step = h.step + 2'h1;
                    next_h.phase = H_LOAD;
                end
                else if (h.reqOp == `OP_RESET)
                begin
                    next_h.cnt = 16'(`HOST_RECOVER_CYC);
                    next_h.phase = H_RECOVER;
                end
                else
                    next_h.phase = H_IDLE;
            H_RECOVER:
                if (h.cnt == 16'h0000)
                    next_h.phase = H_IDLE;
                else
                    next_h.cnt = h.cnt - 16'h0001;
            default:
                next_h.phase = H_IDLE;
        endcase
    end

    // reset starts the power-up wait with the link idle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            h <= '0;
            h.phase <= H_POWER;
            h.cnt <= 16'(POWERUP_CYC);
            h.csN <= 1'h1;
        end
        else
            h <= next_h;
    end

    assign link.csN = h.csN;
    assign link.sclk = h.sclk;
    assign link.mosi = h.txSr[31];
    assign regRdata = h.rdata;
endmodule

// ===== test/flash_lock_monitor.sv
// flash_lock_monitor: timing checks on the serial link wires.
// assumes the host's default sclk half period of 4 core cycles.
`timescale 1ns/1ps
module flash_lock_monitor (
    input wire logic core_clk, // core clock
    input wire logic rst, // synchronous, active high
    input wire logic csN, // chip select, active low
    input wire logic sclk, // link clock
    input wire logic mosi, // host data
    input wire logic miso, // device data
    input wire logic misoOe, // device drive enable
    input wire logic misoLine // resolved wire
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // link clock stands still outside frames, with setup before the first rise
    a_sclk_idle: assert property (csN |-> !sclk)
        else $error("sclk high while deselected");
    a_cs_setup: assert property ($fell(csN) |-> !sclk ##1 !sclk)
        else $error("sclk rose too soon after select");
    // host data moves only on falls and at frame load, so it is steady while sclk is high
    a_mosi_stable: assert property (sclk |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    a_sclk_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("sclk high phase not 4 cycles");
    a_cs_gap: assert property ($rose(csN) |-> csN[*3])
        else $error("deselect gap too short");
    a_powerup_quiet: assert property ($fell(rst) |-> csN[*8])
        else $error("frame during power-up wait");
    // device lets go between frames and answers on falling edges only
    a_miso_release: assert property (csN |-> !misoOe && misoLine)
        else $error("miso driven while deselected");
    a_miso_stable: assert property (misoOe && sclk |-> $stable(miso))
        else $error("miso moved while sclk high");
endmodule

// ===== test/testbench.sv
// testbench: host and device joined by the link, driven from the register port.
// assumes the host sends write enable ahead of every lock or array request.
`timescale 1ns/1ps
`include "flash_lock_regs.svh"
module testbench;
    logic core_clk = 1'h0, rst = 1'h1, regWrite = 1'h0, regRead = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000, regRdata, s;
    logic perUnitProtectSelect = 1'h0, complementProtect = 1'h0;
    logic arrayOpStart, writeEnableLatch, arrayOpErase;
    logic [2:0] protectRangeBits = 3'h0, wrapSettingBits;
    logic [23:0] arrayOpAddr, a, b;
    int mismatches = 0, comparisons = 0, cycles = 0, pulses = 0;
    int seed = 32'h2D7C35B2;
    int lockModel [94];
    spi_link_if link();
    flash_lock_host #(.POWERUP_CYC(20)) flash_lock_host_inst (.core_clk, .rst,
        .link(link.host), .regAddr, .regWdata, .regWrite, .regRead, .regRdata);
    flash_lock_dev #(.ARRAY_OP_CYC(10)) flash_lock_dev_inst (.core_clk, .rst,
        .link(link.dev), .perUnitProtectSelect, .complementProtect,
        .smallUnitSelect(1'h0), .topBottomSelect(1'h0), .protectRangeBits, .busy(),
        .writeEnableLatch, .pausedOperationFlag(), .recovering(), .arrayOpStart,
        .arrayOpErase, .arrayOpAddr, .wrapSettingBits);
    flash_lock_monitor flash_lock_monitor_inst (.core_clk, .rst, .csN(link.csN),
        .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe),
        .misoLine(link.misoLine));
    always #50 core_clk = ~core_clk;
    // count accepted array operations; cut a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (arrayOpStart === 1'h1)
            pulses++;
        if (cycles == 40000)
        begin
            mismatches++;
            $display("unexpected at %0t: run did not finish in time", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= ad;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge core_clk);
        regWrite <= 1'h0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge core_clk);
        regAddr <= ad;
        regRead <= 1'h1;
        @(posedge core_clk);
        regRead <= 1'h0;
        #1 d = regRdata;
    endtask
    // bounded poll; gives up silently after 3000 reads, so a flag that never settles is left to the later checks
    task automatic waitStat(input int pos, input logic val);
        int n;
        n = 0;
        do
        begin
            rd(`REG_STAT, s);
            n++;
        end while (s[pos] !== val && n < 3000);
    endtask
    task automatic run(input logic [7:0] op, input logic [23:0] ad);
        wr(`REG_ADDR, {8'h00, ad});
        wr(`REG_CMD, {24'h000000, op});
        waitStat(0, 1'h0);
    endtask
    // block 0 and block 63 split into sectors, other blocks one bit each
    function automatic int unitOf(input logic [23:0] ad);
        if (ad[21:16] == 6'h00)
            return ad[15:12];
        return ad[21:16] == 6'h3F ? 16 + ad[15:12] : 31 + ad[21:16];
    endfunction
    task automatic checkLock(input logic [23:0] ad);
        run(`OP_READ_LOCK, ad);
        rd(`REG_STAT, s);
        check({24'h000000, s[15:8]}, lockModel[unitOf(ad)]);
    endtask
    task automatic setAll(input int v);
        foreach (lockModel[i])
            lockModel[i] = v;
    endtask
    function automatic logic [23:0] rnd();
        return 24'($random(seed));
    endfunction
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        waitStat(2, 1'h1);
        setAll(1);
        repeat (3) checkLock(rnd());
        run(`OP_GLOBAL_UNLOCK, 24'h000000);
        setAll(0);
        repeat (3) checkLock(rnd());
        a = rnd();
        b = a ^ 24'h010000;
        run(`OP_LOCK, a);
        lockModel[unitOf(a)] = 1;
        checkLock(a);
        checkLock(b);
        run(`OP_UNLOCK, a);
        lockModel[unitOf(a)] = 0;
        checkLock(a);
        run(`OP_LOCK, a);
        lockModel[unitOf(a)] = 1;
        perUnitProtectSelect <= 1'h1;
        run(`OP_ERASE, a);
        check(pulses, 0);
        run(`OP_ERASE, b);
        check(pulses, 1);
        check({8'h00, arrayOpAddr}, {8'h00, b});
        check(arrayOpErase, 1);
        perUnitProtectSelect <= 1'h0;
        run(`OP_PROGRAM, a);
        check(pulses, 2);
        check(arrayOpErase, 0);
        // top block under a one-block range, then the range inverted
        protectRangeBits <= 3'h1;
        run(`OP_PROGRAM, 24'h3F0000);
        check(pulses, 2);
        complementProtect <= 1'h1;
        run(`OP_PROGRAM, 24'h3F0000);
        check(pulses, 3);
        run(`OP_PROGRAM, 24'h000000);
        check(pulses, 3);
        run(`OP_GLOBAL_LOCK, 24'h000000);
        setAll(1);
        checkLock(b);
        run(`OP_GLOBAL_UNLOCK, 24'h000000);
        run(`OP_WRAP, 24'h000070);
        check(wrapSettingBits, 7);
        run(`OP_RESET, 24'h000000);
        setAll(1);
        check(writeEnableLatch, 0);
        check(wrapSettingBits, 0);
        checkLock(b);
        end_of_test();
    end
endmodule
